// ==== design/mef_status.sv ====
// Event status register of the metering engine, with the sign register.
// Assumes all event sources run on clk_sys_in; access is by the host port
// register strobes, one cycle each.
//
// Operation
// RL1 - Total active bit 30 change sets bit 0
// RL2 - Fundamental active bit 30 change sets bit 1
// RL3 - Total reactive bit 30 change sets bit 2
// RL4 - Fundamental reactive bit 30 change sets bit 3
// RL5 - Apparent bit 30 change sets bit 4
// RL6 - Line cycle integration end sets bit 5
// RL7 - Active sign change sets bits 6-8
// RL8 - Pulse 1 sum sign change sets bit 9
// RL9 - Reactive sign change sets bits 10-12
// RL10 - Pulse 2 sum sign change sets bit 13
// RL11 - Pulse 3 sum sign change sets bit 18
// RL12 - Pulse 1 falling edge sets bit 14
// RL13 - Pulse 2, 3 falling edges set 15, 16
// RL14 - Mode fields select pulse power source
// RL15 - DSP cycle completion sets bit 17
// RL16 - Bits 31 to 19 read zero
// RL17 - Register sits at address 0xE502
// RL18 - Write one clears, write zero keeps
// RL19 - Reset clears every flag
`timescale 1ns/1ps
module mef_status
   import mef_pkg::*;
(
   input  wire logic            clk_sys_in,
   input  wire logic            rst_n_in,
   input  wire logic [15:0]     reg_addr_in,
   input  wire logic            reg_wr_in,
   input  wire logic            reg_rd_in,
   input  wire logic [31:0]     reg_wdata_in,
   output logic      [31:0]     reg_rdata_out,
   output logic                 reg_ack_out,
   input  wire logic [1:0]      measurement_mode_in,
   input  wire logic [11:0]     pulse_output_mode_in,
   input  wire mef_half_t       half_bits_in,
   input  wire logic            line_cycle_done_in,
   input  wire mef_phase_sign_t phase_sign_in,
   input  wire mef_sum_sign_t   sum_sign_in,
   input  wire logic [2:0]      pulse_level_n_in,
   input  wire logic            dsp_cycle_done_in,
   output logic      [8:0]      power_sign_out,
   output logic      [2:0]      pulse_out_n_out,
   output logic      [31:0]     energy_event_status_out
);

   // ****************************************************************
   // Source selection
   // ****************************************************************
   function automatic logic mef_pick(input logic [2:0]    src,
                                     input mef_sum_sign_t s);
      logic r;
      r = s.total_active;
      case (src)
         MEF_SRC_TOT_ACT:  r = s.total_active;
         MEF_SRC_TOT_REA:  r = s.total_reactive;
         MEF_SRC_APPARENT: r = s.apparent;
         MEF_SRC_FND_ACT:  r = s.fund_active;
         MEF_SRC_FND_REA:  r = s.fund_reactive;
         default:          r = s.total_active;
      endcase
      return r;
   endfunction : mef_pick

   logic [2:0] act_sign;
   logic [2:0] rea_sign;
   logic [2:0] sum_sign;
   logic [8:0] next_sign;

   always_comb begin
      act_sign = measurement_mode_in[MEF_M_ACT_SEL] ? phase_sign_in.fund_active
                                                    : phase_sign_in.total_active; // RL7
      rea_sign = measurement_mode_in[MEF_M_REA_SEL] ? phase_sign_in.fund_reactive
                                                    : phase_sign_in.total_reactive; // RL9
      sum_sign[0] = mef_pick(pulse_output_mode_in[MEF_C_SRC1 +: 3], sum_sign_in); // RL14
      sum_sign[1] = mef_pick(pulse_output_mode_in[MEF_C_SRC2 +: 3], sum_sign_in); // RL14
      sum_sign[2] = mef_pick(pulse_output_mode_in[MEF_C_SRC3 +: 3], sum_sign_in); // RL14
      next_sign = '0;
      next_sign[MEF_S_ACT_A +: 3] = act_sign;
      next_sign[MEF_S_SUM1]       = sum_sign[0];
      next_sign[MEF_S_REA_A +: 3] = rea_sign;
      next_sign[MEF_S_SUM2]       = sum_sign[1];
      next_sign[MEF_S_SUM3]       = sum_sign[2];
   end

   // ****************************************************************
   // Event detection
   // ****************************************************************
   logic [14:0] half_chg;
   logic [8:0]  sign_chg;
   logic [2:0]  pulse_fall;

   mef_edge_detect #(.W(15)) u_half (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .level_in   (half_bits_in),
      .change_out (half_chg),
      .fall_out   ()
   );

   mef_edge_detect #(.W(9)) u_sign (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .level_in   (next_sign),
      .change_out (sign_chg),
      .fall_out   ()
   );

   // Watches the raw pulse, ahead of the disable gate
   mef_edge_detect #(.W(3)) u_pulse (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .level_in   (pulse_level_n_in),
      .change_out (),
      .fall_out   (pulse_fall)
   );

   logic [MEF_FLAG_W-1:0] set_vec;

   always_comb begin
      set_vec = '0;
      set_vec[MEF_B_TA_HF]       = |half_chg[2:0];   // RL1
      set_vec[MEF_B_FA_HF]       = |half_chg[5:3];   // RL2
      set_vec[MEF_B_TR_HF]       = |half_chg[8:6];   // RL3
      set_vec[MEF_B_FR_HF]       = |half_chg[11:9];  // RL4
      set_vec[MEF_B_AP_HF]       = |half_chg[14:12]; // RL5
      set_vec[MEF_B_LINE]        = line_cycle_done_in; // RL6
      set_vec[MEF_B_ACT_A +: 3]  = sign_chg[MEF_S_ACT_A +: 3]; // RL7
      set_vec[MEF_B_SUM1]        = sign_chg[MEF_S_SUM1]; // RL8
      set_vec[MEF_B_REA_A +: 3]  = sign_chg[MEF_S_REA_A +: 3]; // RL9
      set_vec[MEF_B_SUM2]        = sign_chg[MEF_S_SUM2]; // RL10
      set_vec[MEF_B_SUM3]        = sign_chg[MEF_S_SUM3]; // RL11
      set_vec[MEF_B_PULSE1]      = pulse_fall[0]; // RL12
      set_vec[MEF_B_PULSE1 + 1]  = pulse_fall[1]; // RL13
      set_vec[MEF_B_PULSE1 + 2]  = pulse_fall[2]; // RL13
      set_vec[MEF_B_DSP]         = dsp_cycle_done_in; // RL15
   end

   // ****************************************************************
   // Status register
   // ****************************************************************
   logic                  hit;
   logic [MEF_FLAG_W-1:0] clr_vec;
   logic [MEF_FLAG_W-1:0] flags;

   assign hit     = (reg_addr_in == MEF_STATUS_ADDR); // RL17
   assign clr_vec = (reg_wr_in && hit) ? reg_wdata_in[MEF_FLAG_W-1:0] : '0;

   // Set beats clear so an event in the clearing cycle is kept
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags <= MEF_STATUS_RST[MEF_FLAG_W-1:0]; // RL19
      end else begin
         flags <= (flags & ~clr_vec) | set_vec; // RL18
      end
   end

   assign energy_event_status_out = {{(32-MEF_FLAG_W){1'b0}}, flags}; // RL16

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= MEF_STATUS_RST;
         reg_ack_out   <= 1'b0;
      end else begin
         reg_ack_out <= reg_rd_in || reg_wr_in;
         if (reg_rd_in) begin
            reg_rdata_out <= hit ? energy_event_status_out : 32'h0000_0000; // RL16
         end
      end
   end

   // ****************************************************************
   // Sign register and pulse pins
   // ****************************************************************
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         power_sign_out <= MEF_SIGN_RST;
      end else begin
         power_sign_out <= next_sign; // RL7
      end
   end

   logic [2:0] pulse_dis;
   assign pulse_dis = {pulse_output_mode_in[MEF_C_DIS3],
                       pulse_output_mode_in[MEF_C_DIS2],
                       pulse_output_mode_in[MEF_C_DIS1]};

   // Disabled pins idle high; the flags still see every pulse
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pulse_out_n_out <= 3'h7;
      end else begin
         pulse_out_n_out <= pulse_level_n_in | pulse_dis; // RL13
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_clear_hit(int b);
      reg_wr_in && hit && reg_wdata_in[b];
   endsequence

   sequence s_no_set(int b);
      !set_vec[b];
   endsequence

   total_active_half_a: assert property ( // RL1
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (half_bits_in.total_active != $past(half_bits_in.total_active))
         && $past(rst_n_in) ##1 rst_n_in |-> flags[MEF_B_TA_HF])
      else $error("total active half flag missed");

   apparent_half_a: assert property ( // RL5
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      |half_chg[14:12] |=> flags[MEF_B_AP_HF])
      else $error("apparent half flag missed");

   line_cycle_a: assert property ( // RL6
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      line_cycle_done_in |=> flags[MEF_B_LINE])
      else $error("line cycle flag missed");

   active_sign_a: assert property ( // RL7
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $changed(act_sign) && $past(rst_n_in, 2) |=>
         flags[MEF_B_ACT_A +: 3] != 3'h0 && power_sign_out[2:0] == $past(act_sign))
      else $error("active sign flag or sign bits wrong");

   sum1_sign_a: assert property ( // RL8
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      sign_chg[MEF_S_SUM1] |=> flags[MEF_B_SUM1] && power_sign_out[MEF_S_SUM1] ==
         mef_pick($past(pulse_output_mode_in[2:0]), $past(sum_sign_in)))
      else $error("pulse 1 sum sign wrong");

   pulse_fall_a: assert property ( // RL12
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $fell(pulse_level_n_in[0]) && $past(rst_n_in, 2) |=> flags[MEF_B_PULSE1])
      else $error("pulse 1 edge flag missed");

   pulse_disable_a: assert property ( // RL13
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      pulse_output_mode_in[MEF_C_DIS2] |=> pulse_out_n_out[1])
      else $error("disabled pulse 2 pin not high");

   dsp_done_a: assert property ( // RL15
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      dsp_cycle_done_in ##1 1'b1 |-> flags[MEF_B_DSP])
      else $error("dsp cycle flag missed");

   reserved_zero_a: assert property ( // RL16
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      reg_ack_out |-> reg_rdata_out[31:19] == 13'h0)
      else $error("reserved bits not zero");

   status_read_a: assert property ( // RL17
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      reg_rd_in && reg_addr_in == 16'he502 |=>
         reg_rdata_out == $past(energy_event_status_out))
      else $error("status read data wrong");

   write_clear_a: assert property ( // RL18
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_clear_hit(MEF_B_LINE) and s_no_set(MEF_B_LINE) |=> !flags[MEF_B_LINE])
      else $error("write one did not clear");

   write_keep_a: assert property ( // RL18
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      flags[MEF_B_DSP] && !(reg_wr_in && hit && reg_wdata_in[MEF_B_DSP])
         |=> flags[MEF_B_DSP])
      else $error("flag lost without a clear");

   reset_clear_a: assert property ( // RL19
      @(posedge clk_sys_in)
      $rose(rst_n_in) |-> flags == '0 && reg_rdata_out == 32'h0000_0000)
      else $error("flags not zero after reset");

   sign_reset_a: assert property ( // RL19
      @(posedge clk_sys_in)
      $rose(rst_n_in) |-> power_sign_out == MEF_SIGN_RST && pulse_out_n_out == 3'h7)
      else $error("sign or pulse pins not idle after reset");

   fund_active_half_a: assert property ( // RL2
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $changed(half_bits_in.fund_active) && $past(rst_n_in, 2) |=> flags[MEF_B_FA_HF])
      else $error("fundamental active half flag missed");

   total_reactive_half_a: assert property ( // RL3
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $changed(half_bits_in.total_reactive) && $past(rst_n_in, 2) |=> flags[MEF_B_TR_HF])
      else $error("total reactive half flag missed");

   fund_reactive_half_a: assert property ( // RL4
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $changed(half_bits_in.fund_reactive) && $past(rst_n_in, 2) |=> flags[MEF_B_FR_HF])
      else $error("fundamental reactive half flag missed");

   reactive_sign_a: assert property ( // RL9
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $changed(rea_sign) && $past(rst_n_in, 2) |=> flags[MEF_B_REA_A +: 3] != 3'h0
         && power_sign_out[MEF_S_REA_A +: 3] == $past(rea_sign))
      else $error("reactive sign flag or sign bits wrong");

   sum2_sign_a: assert property ( // RL10
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      sign_chg[MEF_S_SUM2] |=> flags[MEF_B_SUM2] && power_sign_out[MEF_S_SUM2] ==
         mef_pick($past(pulse_output_mode_in[5:3]), $past(sum_sign_in)))
      else $error("pulse 2 sum sign wrong");

   sum3_sign_a: assert property ( // RL11
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      sign_chg[MEF_S_SUM3] |=> flags[MEF_B_SUM3] && power_sign_out[MEF_S_SUM3] ==
         mef_pick($past(pulse_output_mode_in[8:6]), $past(sum_sign_in)))
      else $error("pulse 3 sum sign wrong");

   pulse2_fall_a: assert property ( // RL13
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $fell(pulse_level_n_in[1]) && $past(rst_n_in, 2) |=> flags[MEF_B_PULSE1 + 1])
      else $error("pulse 2 edge flag missed");

   pulse3_fall_a: assert property ( // RL13
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $fell(pulse_level_n_in[2]) && $past(rst_n_in, 2) |=> flags[MEF_B_PULSE1 + 2])
      else $error("pulse 3 edge flag missed");

   pulse1_disable_a: assert property ( // RL12
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      pulse_output_mode_in[MEF_C_DIS1] |=> pulse_out_n_out[0])
      else $error("disabled pulse 1 pin not high");

   pulse3_disable_a: assert property ( // RL13
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      pulse_output_mode_in[MEF_C_DIS3] |=> pulse_out_n_out[2])
      else $error("disabled pulse 3 pin not high");

   pulse_pass_a: assert property ( // RL12
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      !pulse_output_mode_in[MEF_C_DIS1] |=> pulse_out_n_out[0] == $past(pulse_level_n_in[0]))
      else $error("enabled pulse 1 pin does not follow the pulse");

   register_ack_a: assert property ( // RL17
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      reg_rd_in || reg_wr_in |=> reg_ack_out)
      else $error("register access not acknowledged");

endmodule : mef_status

// ==== design/mef_pkg.sv ====
// Constants and carrier types for the metering event status flags.
// Assumes one 20 MHz system clock shared with the metering datapath.
package mef_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [15:0] MEF_STATUS_ADDR  = 16'he502;
   localparam int          MEF_FLAG_W       = 19;
   localparam logic [31:0] MEF_STATUS_RST   = 32'h0000_0000;
   localparam logic [8:0]  MEF_SIGN_RST     = 9'h000;

   // ****************************************************************
   // Status bit positions
   // ****************************************************************
   localparam int MEF_B_TA_HF   = 0;
   localparam int MEF_B_FA_HF   = 1;
   localparam int MEF_B_TR_HF   = 2;
   localparam int MEF_B_FR_HF   = 3;
   localparam int MEF_B_AP_HF   = 4;
   localparam int MEF_B_LINE    = 5;
   localparam int MEF_B_ACT_A   = 6;
   localparam int MEF_B_SUM1    = 9;
   localparam int MEF_B_REA_A   = 10;
   localparam int MEF_B_SUM2    = 13;
   localparam int MEF_B_PULSE1  = 14;
   localparam int MEF_B_DSP     = 17;
   localparam int MEF_B_SUM3    = 18;

   // ****************************************************************
   // Sign register bit positions
   // ****************************************************************
   localparam int MEF_S_ACT_A   = 0;
   localparam int MEF_S_SUM1    = 3;
   localparam int MEF_S_REA_A   = 4;
   localparam int MEF_S_SUM2    = 7;
   localparam int MEF_S_SUM3    = 8;

   // ****************************************************************
   // Mode register fields
   // ****************************************************************
   localparam int MEF_M_ACT_SEL = 0;
   localparam int MEF_M_REA_SEL = 1;
   localparam int MEF_C_SRC1    = 0;
   localparam int MEF_C_SRC2    = 3;
   localparam int MEF_C_SRC3    = 6;
   localparam int MEF_C_DIS1    = 9;
   localparam int MEF_C_DIS2    = 10;
   localparam int MEF_C_DIS3    = 11;

   // Pulse source codes
   localparam logic [2:0] MEF_SRC_TOT_ACT  = 3'h0;
   localparam logic [2:0] MEF_SRC_TOT_REA  = 3'h1;
   localparam logic [2:0] MEF_SRC_APPARENT = 3'h2;
   localparam logic [2:0] MEF_SRC_FND_ACT  = 3'h3;
   localparam logic [2:0] MEF_SRC_FND_REA  = 3'h4;

   // Bit 30 of each accumulator, phases C,B,A in [2:0]
   typedef struct packed {
      logic [2:0] apparent;
      logic [2:0] fund_reactive;
      logic [2:0] total_reactive;
      logic [2:0] fund_active;
      logic [2:0] total_active;
   } mef_half_t;

   // Per-phase power sign, 1 = negative, phases C,B,A
   typedef struct packed {
      logic [2:0] fund_reactive;
      logic [2:0] total_reactive;
      logic [2:0] fund_active;
      logic [2:0] total_active;
   } mef_phase_sign_t;

   // Sign of the three-phase sum for each power type
   typedef struct packed {
      logic fund_reactive;
      logic fund_active;
      logic apparent;
      logic total_reactive;
      logic total_active;
   } mef_sum_sign_t;

endpackage : mef_pkg

// ==== design/mef_edge_detect.sv ====
// Change and falling-edge detector for a vector of same-clock levels.
// Assumes inputs come from logic on the same clock; no synchroniser.
`timescale 1ns/1ps
module mef_edge_detect #(
   parameter int W = 1
) (
   input  wire logic         clk_sys_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] level_in,
   output logic      [W-1:0] change_out,
   output logic      [W-1:0] fall_out
);

   logic [W-1:0] prev;
   logic         primed;

   // No event until a first sample exists, so reset is not a change
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prev   <= '0;
         primed <= 1'b0;
      end else begin
         prev   <= level_in;
         primed <= 1'b1;
      end
   end

   assign change_out = primed ? (prev ^ level_in) : '0;
   assign fall_out   = primed ? (prev & ~level_in) : '0;

endmodule : mef_edge_detect

// ==== dv/tb.sv ====
// Self-checking bench for the metering event status register.
// Assumes mef_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module tb;
   import mef_pkg::*;
   typedef struct {logic [31:0] st; logic [31:0] so; logic [8:0] sg; logic [2:0] pn; bit rd;}
      mef_note_t;
   logic            clk_sys_in, rst_n_in, wr, rd, line_done, dsp, ack;
   logic [15:0]     addr;
   logic [31:0]     wdata, rdata, st_out, exp_st;
   logic [1:0]      meas_mode;
   logic [11:0]     pulse_mode;
   logic [2:0]      pls_n, pin_n;
   logic [8:0]      sign;
   mef_half_t       half;
   mef_phase_sign_t psign;
   mef_sum_sign_t   ssign;
   mef_note_t       notes[$];
   mef_note_t       seen;
   int              err_total, samples_checked, ia, ir;

   mef_status u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .reg_ack_out(ack), .measurement_mode_in(meas_mode), .pulse_output_mode_in(pulse_mode),
      .half_bits_in(half), .line_cycle_done_in(line_done), .phase_sign_in(psign),
      .sum_sign_in(ssign), .pulse_level_n_in(pls_n), .dsp_cycle_done_in(dsp),
      .power_sign_out(sign), .pulse_out_n_out(pin_n), .energy_event_status_out(st_out));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic int sidx(input logic [2:0] c);
      return (c > 3'h4) ? 0 : int'(c);
   endfunction : sidx

   function automatic logic [8:0] exp_sign();
      logic [2:0] a, r;
      a = meas_mode[0] ? psign.fund_active : psign.total_active;
      r = meas_mode[1] ? psign.fund_reactive : psign.total_reactive;
      return {ssign[sidx(pulse_mode[8:6])], ssign[sidx(pulse_mode[5:3])], r,
              ssign[sidx(pulse_mode[2:0])], a};
   endfunction : exp_sign

   task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (e !== s) begin
         err_total++;
         $display("wrong value %s: expected %h, seen %h", what, e, s);
      end
   endtask : check

   task automatic settle();
      repeat (3) @(posedge clk_sys_in);
   endtask : settle

   // Note is taken when the strobe is driven; flags must already be settled
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      mef_note_t n;
      @(posedge clk_sys_in);
      addr  <= a;
      wr    <= w;
      rd    <= !w;
      wdata <= d;
      n.st = (a == MEF_STATUS_ADDR) ? exp_st : 32'h0000_0000;
      n.sg = exp_sign();
      n.rd = !w;
      n.pn = pls_n | pulse_mode[11:9];
      if (w && a == MEF_STATUS_ADDR) begin
         exp_st = exp_st & ~d;
      end
      n.so = exp_st;
      notes.push_back(n);
      @(posedge clk_sys_in);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   task automatic rd_st();
      bus(1'b0, MEF_STATUS_ADDR, 32'h0000_0000);
   endtask : rd_st

   task automatic clr();
      settle();
      bus(1'b1, MEF_STATUS_ADDR, 32'hffff_ffff);
   endtask : clr

   task automatic done(input string name);
      settle();
      $display("test %s done", name);
   endtask : done

   task automatic conclude();
      if (notes.size() != 0) begin
         err_total++;
         $display("wrong value pending_acks: expected 0, seen %0d", notes.size());
      end
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   // ****************************************************************
   // Clock, monitor, watchdog
   // ****************************************************************
   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in) begin
      if (ack === 1'b1) begin
         if (notes.size() == 0) begin
            err_total++;
            $display("wrong value ack: expected none, seen %h", rdata);
         end else begin
            seen = notes.pop_front();
            check("sign", {23'h0, seen.sg}, {23'h0, sign});
            check("status_out", seen.so, st_out);
            check("pulse_pins", {29'h0, seen.pn}, {29'h0, pin_n});
            if (seen.rd) begin
               check("status", seen.st, rdata);
            end
         end
      end
   end

   // Whole run needs about 720 cycles
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      err_total++;
      $display("wrong value watchdog: expected finish, seen timeout");
      conclude();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      {wr, rd, line_done, dsp, addr, wdata, meas_mode, pulse_mode, half, psign, ssign} = '0;
      pls_n = 3'h7;
      exp_st = 32'h0000_0000;
      rst_n_in = 1'b0;
      void'($urandom(83062));
      repeat (5) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      settle();
      rd_st();
      done("reset");
      for (int i = 0; i < 15; i++) begin
         @(posedge clk_sys_in);
         half[i] <= ~half[i];
         settle();
         exp_st[i / 3] = 1'b1;
         rd_st();
         bus(1'b1, MEF_STATUS_ADDR, 32'h0000_0000);
         bus(1'b1, MEF_STATUS_ADDR, ($urandom() & 32'hfff8_0000) | (32'h1 << (i / 3)));
         rd_st();
      end
      done("half_full");
      @(posedge clk_sys_in);
      line_done <= 1'b1;
      @(posedge clk_sys_in);
      line_done <= 1'b0;
      dsp <= 1'b1;
      @(posedge clk_sys_in);
      dsp <= 1'b0;
      settle();
      exp_st[5] = 1'b1;
      exp_st[17] = 1'b1;
      rd_st();
      done("line_dsp");
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 3; p++) begin
            @(posedge clk_sys_in);
            meas_mode <= 2'(m);
            clr();
            ia = m[0] ? p : 3 + p;
            ir = m[1] ? 6 + p : 9 + p;
            psign[ia] <= ~psign[ia];
            psign[ir] <= ~psign[ir];
            settle();
            rd_st();
            ia = m[0] ? 3 + p : p;
            ir = m[1] ? 9 + p : 6 + p;
            psign[ia] <= ~psign[ia];
            psign[ir] <= ~psign[ir];
            settle();
            exp_st[6 + p] = 1'b1;
            exp_st[10 + p] = 1'b1;
            rd_st();
         end
      end
      done("phase_sign");
      for (int k = 0; k < 3; k++) begin
         for (int c = 0; c < 8; c++) begin
            @(posedge clk_sys_in);
            pulse_mode[3 * k +: 3] <= 3'(c);
            pulse_mode[11:9] <= 3'($urandom());
            clr();
            ssign[sidx(3'(c))] <= ~ssign[sidx(3'(c))];
            settle();
            for (int j = 0; j < 3; j++) begin
               if (sidx(pulse_mode[3 * j +: 3]) == sidx(3'(c))) begin
                  exp_st[(j == 0) ? 9 : (j == 1) ? 13 : 18] = 1'b1;
               end
            end
            rd_st();
         end
      end
      done("sum_sign");
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_sys_in);
         pulse_mode[9 + k] <= 1'($urandom());
         pls_n[k] <= 1'b0;
         exp_st[14 + k] = 1'b1;
         // Read while the pulse is still low, so the pin gate is seen
         rd_st();
         @(posedge clk_sys_in);
         pls_n[k] <= 1'b1;
         settle();
         rd_st();
      end
      done("pulse");
      bus(1'b0, MEF_STATUS_ADDR + 16'h0001, 32'h0000_0000);
      bus(1'b1, 16'he501, 32'hffff_ffff);
      rd_st();
      done("address");
      // Zero the signs first so the sign register expectation holds over reset
      @(posedge clk_sys_in);
      psign <= '0;
      ssign <= '0;
      settle();
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      exp_st = 32'h0000_0000;
      settle();
      rd_st();
      done("mid_reset");
      conclude();
   end
endmodule : tb
